// File: core/tss_pkg.sv
// shared constants and types of the test start/stop sequencer
package tss_pkg;

   // ***************************************************************
   // register map (byte addresses, one 32-bit word each)
   // ***************************************************************
   localparam int TSS_ADDR_W = 8;
   localparam int TSS_DATA_W = 32;
   localparam logic [TSS_ADDR_W-1:0] TSS_OFF_CTRL = 8'h00;
   localparam logic [TSS_ADDR_W-1:0] TSS_OFF_STATUS = 8'h04;
   localparam logic [TSS_ADDR_W-1:0] TSS_OFF_COUNT = 8'h08;
   localparam logic [TSS_ADDR_W-1:0] TSS_OFF_IRQ_STATUS = 8'h0c;
   localparam logic [TSS_ADDR_W-1:0] TSS_OFF_IRQ_MASK = 8'h10;
   localparam logic [TSS_ADDR_W-1:0] TSS_OFF_LIST = 8'h20;
   localparam logic [1:0] TSS_WORD_ALIGN = 2'h0;

   // ***************************************************************
   // field positions
   // ***************************************************************
   localparam int TSS_CTRL_RUN_BIT = 0;
   localparam int TSS_CTRL_KEEP_CLK_BIT = 1;
   localparam int TSS_STAT_MEAS_BUSY_BIT = 0;
   localparam int TSS_STAT_CLK_ON_BIT = 1;
   localparam int TSS_STAT_SEQ_BUSY_BIT = 2;
   localparam int TSS_IRQ_W = 3;
   localparam int TSS_IRQ_START_DONE_BIT = 0;
   localparam int TSS_IRQ_STOP_DONE_BIT = 1;
   localparam int TSS_IRQ_REFUSED_BIT = 2;

   // ***************************************************************
   // reset values and timing
   // ***************************************************************
   localparam logic TSS_BP_CLK_RST = 1'b0;
   localparam logic TSS_KEEP_CLK_RST = 1'b0;
   localparam logic [TSS_IRQ_W-1:0] TSS_IRQ_MASK_RST = 3'h0;
   localparam int TSS_CLK_SETTLE_CYCLES = 4;

   // ***************************************************************
   // commands sent to a backplane measurement module
   // ***************************************************************
   typedef enum logic [1:0] {
      TSS_OP_TRIG_CLEAR,
      TSS_OP_CONFIG_MODE,
      TSS_OP_MEAS_MODE,
      TSS_OP_TRIG_SET
   } tss_op_t;

endpackage

// File: core/tss_cmd_port.sv
// one outstanding command to a backplane module, held until the module acknowledges
`timescale 1ns/1ps
`default_nettype none
module tss_cmd_port #(
   parameter int SLOT_W = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic [SLOT_W-1:0] slot_i,
   input wire tss_pkg::tss_op_t op_i,
   input wire logic mod_cmd_ack_i,
   output logic mod_cmd_valid_o,
   output logic [SLOT_W-1:0] mod_cmd_slot_o,
   output tss_pkg::tss_op_t mod_cmd_op_o,
   output logic done_o
);
   import tss_pkg::*;

   typedef struct packed {
      logic valid;
      logic [SLOT_W-1:0] slot;
      tss_op_t op;
      logic done;
   } tss_port_t;

   tss_port_t q;
   tss_port_t d;

   always_comb
   begin
      d = q;
      d.done = 1'b0;
      // a go while busy cannot occur: the sequencer waits for done
      if (!q.valid && go_i)
      begin
         d.valid = 1'b1;
         d.slot = slot_i;
         d.op = op_i;
      end
      else if (q.valid && mod_cmd_ack_i)
      begin
         d.valid = 1'b0;
         d.done = 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
         q.op <= TSS_OP_TRIG_CLEAR;
      end
      else
      begin
         q <= d;
      end
   end

   assign mod_cmd_valid_o = q.valid;
   assign mod_cmd_slot_o = q.slot;
   assign mod_cmd_op_o = q.op;
   assign done_o = q.done;

endmodule
`default_nettype wire

// File: core/tss_sequencer.sv
// test start/stop sequencer with wishbone registers and backplane command port
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - control write with run 1 starts or restarts, run 0 stops a measurement
// - keep-clock bit: 1 keeps backplane clock on during test, 0 (default) off
// - status bit 0 mirrors the backplane ready line: 1 busy, 0 finished
// - status bit 1 is 1 while backplane clock runs, 0 while stopped
// - start first turns backplane clock on, whatever the keep-clock bit says
// - start step two clears each listed module's trigger, first module first
// - start step three sets configuration mode in list order
// - start step four sets measurement mode in reverse list order
// - start step five sets trigger active in reverse list order
// - start ends by turning the clock off when keep-clock is 0
// - stop: clock on, clear triggers in order, configuration mode in order
// - only listed modules take part, approached in list order, but in reverse order for measurement mode and trigger set
module tss_sequencer #(
   parameter int MAX_MODS = 8,
   parameter int SLOT_W = 4,
   parameter int CLK_SETTLE = tss_pkg::TSS_CLK_SETTLE_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [tss_pkg::TSS_ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [tss_pkg::TSS_DATA_W-1:0] wb_dat_i,
   output logic [tss_pkg::TSS_DATA_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   input wire logic bp_meas_busy_i,
   output logic bp_clk_en_o,
   output logic seq_busy_o,
   output logic mod_cmd_valid_o,
   output logic [SLOT_W-1:0] mod_cmd_slot_o,
   output tss_pkg::tss_op_t mod_cmd_op_o,
   input wire logic mod_cmd_ack_i
);
   import tss_pkg::*;

   localparam int CNT_W = $clog2(MAX_MODS + 1);
   localparam int IDX_W = $clog2(MAX_MODS);
   localparam int SET_W = $clog2(CLK_SETTLE + 1);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef enum logic [2:0] {
      S_IDLE,
      S_CLK_ON,
      S_TRIG_CLR,
      S_CONFIG,
      S_MEAS,
      S_TRIG_SET,
      S_FINISH
   } tss_state_t;

   typedef struct packed {
      tss_state_t st;
      logic wait_ack;
      logic [IDX_W-1:0] idx;
      logic [CNT_W-1:0] count;
      logic [MAX_MODS-1:0][SLOT_W-1:0] slots;
      logic run;
      logic keep_clk;
      logic clk_en;
      logic [SET_W-1:0] settle;
      logic [TSS_IRQ_W-1:0] irq_st;
      logic [TSS_IRQ_W-1:0] irq_mask;
      logic ack;
      logic [TSS_DATA_W-1:0] rdat;
      logic go;
      logic [SLOT_W-1:0] go_slot;
      tss_op_t go_op;
   } tss_main_t;

   tss_main_t q;
   tss_main_t d;

   logic cmd_done;
   logic bus_req;
   logic idle;
   logic [TSS_IRQ_W-1:0] irq_set;
   logic [TSS_IRQ_W-1:0] irq_clr;
   logic [TSS_DATA_W-1:0] rd_word;
   logic [CNT_W-1:0] wr_count;
   tss_state_t nxt;

   // ***************************************************************
   // helpers
   // ***************************************************************
   function automatic logic list_hit(input logic [TSS_ADDR_W-1:0] a);
      logic [TSS_ADDR_W-1:0] off;
      off = TSS_ADDR_W'(a - TSS_OFF_LIST);
      return (a >= TSS_OFF_LIST) && (off[1:0] == TSS_WORD_ALIGN)
         && (off[TSS_ADDR_W-1:2] < (TSS_ADDR_W-2)'(MAX_MODS));
   endfunction

   function automatic logic [IDX_W-1:0] list_idx(input logic [TSS_ADDR_W-1:0] a);
      logic [TSS_ADDR_W-1:0] off;
      off = TSS_ADDR_W'(a - TSS_OFF_LIST);
      return IDX_W'(off[TSS_ADDR_W-1:2]);
   endfunction

   // measurement mode and trigger set walk the list backwards
   function automatic logic is_rev(input tss_state_t s);
      return (s == S_MEAS) || (s == S_TRIG_SET);
   endfunction

   function automatic logic [IDX_W-1:0] first_idx(input tss_state_t s,
                                                 input logic [CNT_W-1:0] n);
      return is_rev(s) ? IDX_W'(n - 1'b1) : '0;
   endfunction

   function automatic logic is_last(input tss_state_t s, input logic [IDX_W-1:0] i,
                                    input logic [CNT_W-1:0] n);
      return is_rev(s) ? (i == '0) : (i == IDX_W'(n - 1'b1));
   endfunction

   function automatic tss_state_t next_step(input tss_state_t s, input logic run);
      tss_state_t r;
      r = S_IDLE;
      case (s)
         S_TRIG_CLR: r = S_CONFIG;
         S_CONFIG: r = run ? S_MEAS : S_FINISH;
         S_MEAS: r = S_TRIG_SET;
         S_TRIG_SET: r = S_FINISH;
         default: r = S_IDLE;
      endcase
      return r;
   endfunction

   function automatic tss_op_t step_op(input tss_state_t s);
      tss_op_t r;
      r = TSS_OP_TRIG_CLEAR;
      case (s)
         S_TRIG_CLR: r = TSS_OP_TRIG_CLEAR;
         S_CONFIG: r = TSS_OP_CONFIG_MODE;
         S_MEAS: r = TSS_OP_MEAS_MODE;
         S_TRIG_SET: r = TSS_OP_TRIG_SET;
         default: r = TSS_OP_TRIG_CLEAR;
      endcase
      return r;
   endfunction

   // ***************************************************************
   // register read mux
   // ***************************************************************
   always_comb
   begin
      rd_word = '0;
      case (wb_adr_i)
         TSS_OFF_CTRL:
         begin
            rd_word[TSS_CTRL_RUN_BIT] = q.run;
            rd_word[TSS_CTRL_KEEP_CLK_BIT] = q.keep_clk;
         end
         TSS_OFF_STATUS:
         begin
            rd_word[TSS_STAT_MEAS_BUSY_BIT] = bp_meas_busy_i;
            rd_word[TSS_STAT_CLK_ON_BIT] = q.clk_en;
            rd_word[TSS_STAT_SEQ_BUSY_BIT] = (q.st != S_IDLE);
         end
         TSS_OFF_COUNT: rd_word[CNT_W-1:0] = q.count;
         TSS_OFF_IRQ_STATUS: rd_word[TSS_IRQ_W-1:0] = q.irq_st;
         TSS_OFF_IRQ_MASK: rd_word[TSS_IRQ_W-1:0] = q.irq_mask;
         default:
         begin
            // unmapped words read as zero
            if (list_hit(wb_adr_i))
            begin
               rd_word[SLOT_W-1:0] = q.slots[list_idx(wb_adr_i)];
            end
         end
      endcase
   end

   // ***************************************************************
   // bus slave and sequencer
   // ***************************************************************
   always_comb
   begin
      d = q;
      d.ack = 1'b0;
      d.go = 1'b0;
      irq_set = '0;
      irq_clr = '0;
      idle = (q.st == S_IDLE);
      bus_req = wb_cyc_i && wb_stb_i && !q.ack;
      wr_count = wb_dat_i[CNT_W-1:0];
      if (wr_count > CNT_W'(MAX_MODS))
      begin
         wr_count = CNT_W'(MAX_MODS);
      end
      nxt = next_step(q.st, q.run);

      if (bus_req)
      begin
         d.ack = 1'b1;
         d.rdat = rd_word;
         if (wb_we_i && wb_sel_i[0])
         begin
            case (wb_adr_i)
               TSS_OFF_CTRL:
               begin
                  if (idle)
                  begin
                     d.run = wb_dat_i[TSS_CTRL_RUN_BIT];
                     d.keep_clk = wb_dat_i[TSS_CTRL_KEEP_CLK_BIT];
                     d.clk_en = 1'b1;
                     d.settle = '0;
                     d.st = S_CLK_ON;
                  end
                  else
                  begin
                     irq_set[TSS_IRQ_REFUSED_BIT] = 1'b1;
                  end
               end
               TSS_OFF_COUNT:
               begin
                  if (idle)
                  begin
                     d.count = wr_count;
                  end
               end
               TSS_OFF_IRQ_STATUS: irq_clr = wb_dat_i[TSS_IRQ_W-1:0];
               TSS_OFF_IRQ_MASK: d.irq_mask = wb_dat_i[TSS_IRQ_W-1:0];
               default:
               begin
                  // the list is frozen while a sequence walks it
                  if (idle && list_hit(wb_adr_i))
                  begin
                     d.slots[list_idx(wb_adr_i)] = wb_dat_i[SLOT_W-1:0];
                  end
               end
            endcase
         end
      end

      case (q.st)
         S_IDLE:
         begin
            d.wait_ack = 1'b0;
         end
         S_CLK_ON:
         begin
            // give the backplane clock a few cycles before the first command
            if (q.settle == SET_W'(CLK_SETTLE - 1))
            begin
               d.st = S_TRIG_CLR;
               d.idx = '0;
            end
            else
            begin
               d.settle = SET_W'(q.settle + 1'b1);
            end
         end
         S_TRIG_CLR, S_CONFIG, S_MEAS, S_TRIG_SET:
         begin
            if (q.count == '0)
            begin
               // empty list: no module takes part, walk straight through
               d.st = nxt;
               d.idx = first_idx(nxt, q.count);
            end
            else if (!q.wait_ack)
            begin
               d.go = 1'b1;
               d.go_slot = q.slots[q.idx];
               d.go_op = step_op(q.st);
               d.wait_ack = 1'b1;
            end
            else if (cmd_done)
            begin
               d.wait_ack = 1'b0;
               if (is_last(q.st, q.idx, q.count))
               begin
                  d.st = nxt;
                  d.idx = first_idx(nxt, q.count);
               end
               else if (is_rev(q.st))
               begin
                  d.idx = IDX_W'(q.idx - 1'b1);
               end
               else
               begin
                  d.idx = IDX_W'(q.idx + 1'b1);
               end
            end
         end
         S_FINISH:
         begin
            if (q.run)
            begin
               d.clk_en = q.keep_clk;
               irq_set[TSS_IRQ_START_DONE_BIT] = 1'b1;
            end
            else
            begin
               irq_set[TSS_IRQ_STOP_DONE_BIT] = 1'b1;
            end
            d.st = S_IDLE;
         end
         default:
         begin
            d.st = S_IDLE;
         end
      endcase

      // an event in the same cycle as its clear stays set
      d.irq_st = (q.irq_st & ~irq_clr) | irq_set;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
         q.st <= S_IDLE;
         q.clk_en <= TSS_BP_CLK_RST;
         q.keep_clk <= TSS_KEEP_CLK_RST;
         q.irq_mask <= TSS_IRQ_MASK_RST;
         q.go_op <= TSS_OP_TRIG_CLEAR;
      end
      else
      begin
         q <= d;
      end
   end

   // ***************************************************************
   // backplane command port
   // ***************************************************************
   tss_cmd_port #(
      .SLOT_W(SLOT_W)
   ) tss_cmd_port_inst (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .go_i(q.go),
      .slot_i(q.go_slot),
      .op_i(q.go_op),
      .mod_cmd_ack_i(mod_cmd_ack_i),
      .mod_cmd_valid_o(mod_cmd_valid_o),
      .mod_cmd_slot_o(mod_cmd_slot_o),
      .mod_cmd_op_o(mod_cmd_op_o),
      .done_o(cmd_done)
   );

   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.rdat;
   assign irq_o = |(q.irq_st & q.irq_mask);
   assign bp_clk_en_o = q.clk_en;
   assign seq_busy_o = (q.st != S_IDLE);

endmodule
`default_nettype wire

// File: tb/tss_properties.sv
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module tss_properties
   import tss_pkg::*;
#(
   parameter int SLOT_W = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [TSS_ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [TSS_DATA_W-1:0] wb_dat_i,
   input wire logic [TSS_DATA_W-1:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic bp_meas_busy_i,
   input wire logic bp_clk_en_o,
   input wire logic seq_busy_o,
   input wire logic mod_cmd_valid_o,
   input wire logic [SLOT_W-1:0] mod_cmd_slot_o,
   input wire tss_op_t mod_cmd_op_o,
   input wire logic mod_cmd_ack_i
);
   logic req;
   logic acc;
   logic st_rd;
   logic start_q;
   logic keep_q;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
   assign acc = req && wb_adr_i == TSS_OFF_CTRL && !seq_busy_o;
   assign st_rd = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == TSS_OFF_STATUS;
   // remembers what kind of sequence is running, for the end-of-run clock checks
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         start_q <= 1'b0;
         keep_q <= 1'b0;
      end
      else if (acc)
      begin
         start_q <= wb_dat_i[TSS_CTRL_RUN_BIT];
         keep_q <= wb_dat_i[TSS_CTRL_KEEP_CLK_BIT];
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   start_clk_on_a: assert property (
      acc |=> bp_clk_en_o && seq_busy_o) else $error("clock not on after request");
   cmd_clk_on_a: assert property (
      mod_cmd_valid_o |-> bp_clk_en_o && seq_busy_o) else $error("command without clock");
   cmd_hold_a: assert property (
      mod_cmd_valid_o && !mod_cmd_ack_i |=> mod_cmd_valid_o && $stable(mod_cmd_slot_o)
      && $stable(mod_cmd_op_o)) else $error("command changed before ack");
   cmd_done_a: assert property (
      mod_cmd_valid_o && mod_cmd_ack_i |=> !mod_cmd_valid_o) else $error("command not retired");
   refuse_busy_a: assert property (
      req && wb_adr_i == TSS_OFF_CTRL && seq_busy_o |=> seq_busy_o) else $error("busy broken");
   clk_off_end_a: assert property (
      $fell(seq_busy_o) && start_q && !keep_q |-> ##[0:1] !bp_clk_en_o)
      else $error("clock left on after start");
   clk_kept_a: assert property (
      $fell(seq_busy_o) && (keep_q || !start_q) |-> bp_clk_en_o) else $error("clock dropped");
   busy_bit_a: assert property (
      wb_ack_o && $past(st_rd) |-> wb_dat_o[0] == $past(bp_meas_busy_i))
      else $error("status busy bit wrong");
   clk_bit_a: assert property (
      wb_ack_o && $past(st_rd) |-> wb_dat_o[1] == $past(bp_clk_en_o))
      else $error("status clock bit wrong");
endmodule
`default_nettype wire

// File: tb/tss_mod_model.sv
// backplane modules: acknowledge each command after a random stall
`timescale 1ns/1ps
`default_nettype none
module tss_mod_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic valid_i,
   output logic ack_o
);
   int seed = 17;
   logic [1:0] wait_q;
   always @(posedge clk_i)
   begin
      ack_o <= 1'b0;
      if (rst_i)
         wait_q <= 2'h0;
      else if (valid_i && !ack_o)
      begin
         if (wait_q == 2'h0)
         begin
            ack_o <= 1'b1;
            wait_q <= 2'($random(seed));
         end
         else
            wait_q <= wait_q - 2'h1;
      end
   end
endmodule
`default_nettype wire

// File: tb/tss_sequencer_tb_top.sv
// self-checking bench for the start/stop sequencer
`timescale 1ns/1ps
`default_nettype none
module tss_sequencer_tb_top;
   import tss_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic busy = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0;
   logic [31:0] wb_dat_o;
   logic [31:0] r;
   logic wb_ack_o, irq_o, bp_clk_en_o, seq_busy_o, mod_cmd_valid_o, mod_cmd_ack_i;
   logic [3:0] mod_cmd_slot_o;
   tss_op_t mod_cmd_op_o;
   logic [5:0] exp_q[$];
   logic [3:0] slots[8];
   int seed = 17;
   int miscompares = 0;
   int total_checks = 0;
   always #25 clk_i = ~clk_i;
   tss_sequencer #(.CLK_SETTLE(1)) tss_sequencer_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .irq_o(irq_o), .bp_meas_busy_i(busy), .bp_clk_en_o(bp_clk_en_o),
      .seq_busy_o(seq_busy_o), .mod_cmd_valid_o(mod_cmd_valid_o),
      .mod_cmd_slot_o(mod_cmd_slot_o), .mod_cmd_op_o(mod_cmd_op_o),
      .mod_cmd_ack_i(mod_cmd_ack_i));
   tss_mod_model tss_mod_model_inst (.clk_i(clk_i), .rst_i(rst_i),
      .valid_i(mod_cmd_valid_o), .ack_o(mod_cmd_ack_i));
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // entered just after a rising edge; the bus is released only after ack is seen
   // no wait limit here: a slave that never answers is caught by the watchdog
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1)
      begin
         @(posedge clk_i);
      end
      r = wb_dat_o;
      cyc <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      wb(1'b0, a, 32'h0);
      chk(n, e, r);
   endtask
   // notes the commands owed by this request, then makes it and waits for idle
   task automatic run(input logic go, input logic keep, input int n);
      int i;
      busy <= 1'($random(seed));
      for (i = 0; i < n; i++) exp_q.push_back({slots[i], TSS_OP_TRIG_CLEAR});
      for (i = 0; i < n; i++) exp_q.push_back({slots[i], TSS_OP_CONFIG_MODE});
      for (i = n - 1; go && i >= 0; i--) exp_q.push_back({slots[i], TSS_OP_MEAS_MODE});
      for (i = n - 1; go && i >= 0; i--) exp_q.push_back({slots[i], TSS_OP_TRIG_SET});
      wb(1'b1, TSS_OFF_CTRL, {30'h0, keep, go});
      if (n > 0)
         wb(1'b1, TSS_OFF_CTRL, {31'h0, !go});
      while (seq_busy_o !== 1'b0)
      begin
         @(posedge clk_i);
      end
      @(posedge clk_i);
      rd(TSS_OFF_CTRL, {30'h0, keep, go}, "ctrl");
      chk("left", 32'h0, 32'(exp_q.size()));
      chk("clk", {31'h0, keep | !go}, {31'h0, bp_clk_en_o});
      rd(TSS_OFF_STATUS, {30'h0, keep | !go, busy}, "status");
      rd(TSS_OFF_IRQ_STATUS, {29'h0, n > 0, !go, go}, "irq_status");
      chk("irq", 32'h1, {31'h0, irq_o});
      wb(1'b1, TSS_OFF_IRQ_STATUS, 32'h7);
      chk("irq_clear", 32'h0, {31'h0, irq_o});
      $display("test run %0d keep %0d mods %0d done", go, keep, n);
   endtask
   always @(posedge clk_i)
      if (mod_cmd_valid_o === 1'b1 && mod_cmd_ack_i === 1'b1)
      begin
         if (exp_q.size() == 0)
            chk("extra", 32'h0, 32'h1);
         else
            chk("cmd", 32'(exp_q.pop_front()), {26'h0, mod_cmd_slot_o, mod_cmd_op_o});
      end
   initial
   begin
      #2000000;
      miscompares++;
      conclude();
   end
   initial
   begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(TSS_OFF_STATUS, 32'h0, "reset_status");
      rd(8'h40, 32'h0, "unmapped");
      wb(1'b1, TSS_OFF_IRQ_MASK, 32'h7);
      chk("irq_idle", 32'h0, {31'h0, irq_o});
      $display("test reset done");
      for (int i = 0; i < 8; i++) slots[i] = 4'($random(seed));
      wb(1'b1, TSS_OFF_COUNT, 32'h3);
      // entry 0 stands for the pattern io module, which must be triggered last
      for (int i = 0; i < 3; i++) wb(1'b1, TSS_OFF_LIST + 8'(4 * i), {28'h0, slots[i]});
      run(1'b1, 1'b0, 3);
      run(1'b0, 1'b0, 3);
      wb(1'b1, TSS_OFF_COUNT, 32'h1);
      run(1'b1, 1'b1, 1);
      wb(1'b1, TSS_OFF_COUNT, 32'h0);
      run(1'b1, 1'b0, 0);
      conclude();
   end
endmodule
bind tss_sequencer tss_properties #(.SLOT_W(SLOT_W)) tss_properties_inst (.clk_i, .rst_i,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
   .bp_meas_busy_i, .bp_clk_en_o, .seq_busy_o, .mod_cmd_valid_o, .mod_cmd_slot_o,
   .mod_cmd_op_o, .mod_cmd_ack_i);
`default_nettype wire
